// ==== cflm_csr_pkg.sv ====
// Constants, field layouts and types for the floating-point, loop and machine CSR bank.
// Notes on behaviour
// - Read-only fields ignore every CSR write.
// - Read/write fields hold the last written value.
// - Exception flags in bits 4:0, rest zero.
// - Rounding mode three bits, upper bits zero.
// - Combined view: rounding 7:5, flags 4:0.
// - Loop start registers read-only, bits 1:0 zero.
// - Loop end registers read-only, bits 1:0 zero.
// - Loop count registers report full iteration count.
// - Previous privilege reads 11 without user mode.
// - Dirty summary set when float state is 11.
// - Float state field writable, zero without unit or with floats in integer registers.
// - Trap saves enable; return restores it.
// - Enable bits 31:16 gate fast interrupt lines.
// - Enables at 11, 7, 3; others zero.
// - Vector base writable 31:8, bits 7:2 zero.
// - Mode bit 1 zero; bit 0 selects dispatch.
// - Reset loads boot vector base, vectored mode.
// - Traps redirect fetch using vector base.
// - Trap saves pc; return reloads it.
package cflm_csr_pkg;

  // CSR addresses.
  localparam logic [11:0] CFLM_ADDR_FP_EXC_FLAGS = 12'h001;
  localparam logic [11:0] CFLM_ADDR_FP_ROUND     = 12'h002;
  localparam logic [11:0] CFLM_ADDR_FP_CTRL_STAT = 12'h003;
  localparam logic [11:0] CFLM_ADDR_STATE_WORD   = 12'h300;
  localparam logic [11:0] CFLM_ADDR_IRQ_ENABLE   = 12'h304;
  localparam logic [11:0] CFLM_ADDR_TRAP_VECTOR  = 12'h305;
  localparam logic [11:0] CFLM_ADDR_SCRATCHPAD   = 12'h340;
  localparam logic [11:0] CFLM_ADDR_LOOP0_BEGIN  = 12'hcc0;
  localparam logic [11:0] CFLM_ADDR_LOOP0_FINISH = 12'hcc1;
  localparam logic [11:0] CFLM_ADDR_LOOP0_ITER   = 12'hcc2;
  localparam logic [11:0] CFLM_ADDR_LOOP1_BEGIN  = 12'hcc4;
  localparam logic [11:0] CFLM_ADDR_LOOP1_FINISH = 12'hcc5;
  localparam logic [11:0] CFLM_ADDR_LOOP1_ITER   = 12'hcc6;

  // Machine state word field positions.
  localparam int CFLM_POS_DIRTY_SUMMARY = 31;
  localparam int CFLM_POS_FP_STATE      = 13;
  localparam int CFLM_POS_PREV_PRIV     = 11;
  localparam int CFLM_POS_PREV_IRQ_EN   = 7;
  localparam int CFLM_POS_GLOBAL_IRQ_EN = 3;

  // Interrupt enable mask: fast lines 31:16 plus external, timer, software.
  localparam logic [31:0] CFLM_IRQ_ENABLE_WMASK = 32'hffff_0888;

  // Values after reset and fixed encodings.
  localparam logic [1:0]  CFLM_PRIV_MACHINE    = 2'h3;
  localparam logic [1:0]  CFLM_FP_STATE_OFF    = 2'h0;
  localparam logic [1:0]  CFLM_FP_STATE_INIT   = 2'h1;
  localparam logic [1:0]  CFLM_FP_STATE_CLEAN  = 2'h2;
  localparam logic [1:0]  CFLM_FP_STATE_DIRTY  = 2'h3;
  localparam logic [4:0]  CFLM_FLAGS_RESET     = 5'h00;
  localparam logic [2:0]  CFLM_ROUND_RESET     = 3'h0;
  localparam logic [31:0] CFLM_WORD_RESET      = 32'h0000_0000;
  localparam logic [5:0]  CFLM_TVEC_LOW_ZERO   = 6'h00;
  localparam logic [1:0]  CFLM_TVEC_MODE_RESET = 2'h1;

  // Rounding mode codes.
  localparam logic [2:0] CFLM_RND_NEAREST_EVEN = 3'h0;
  localparam logic [2:0] CFLM_RND_TOWARD_ZERO  = 3'h1;
  localparam logic [2:0] CFLM_RND_DOWN         = 3'h2;
  localparam logic [2:0] CFLM_RND_UP           = 3'h3;
  localparam logic [2:0] CFLM_RND_NEAREST_MAX  = 3'h4;
  localparam logic [2:0] CFLM_RND_DYNAMIC      = 3'h7;

  // CSR instruction operations.
  typedef enum logic [1:0] {
    CFLM_OP_READ,
    CFLM_OP_WRITE,
    CFLM_OP_SET,
    CFLM_OP_CLEAR
  } cflm_op_t;

endpackage

// ==== cflm_csr_bank.sv ====
// CSR bank for floating-point flags and rounding, hardware loops and machine trap state.
`timescale 1ns/1ps

module cflm_csr_bank
  import cflm_csr_pkg::*;
#(
  parameter bit float_unit_present      = 1'b1,
  parameter bit float_in_int_regs       = 1'b0,
  parameter bit custom_extension_enable = 1'b1,
  parameter bit user_mode_enable        = 1'b0
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Boot configuration.
  input  wire logic [31:0] boot_vector_addr,
  // CSR instruction request.
  input  wire logic        csr_req,
  input  wire cflm_op_t    csr_op,
  input  wire logic [11:0] csr_addr,
  input  wire logic [31:0] csr_wdata,
  // CSR instruction answer.
  output logic             csr_rvalid,
  output logic [31:0]      csr_rdata,
  output logic             csr_illegal,
  // Floating-point unit status.
  input  wire logic [4:0]  fp_flags_raise,
  input  wire logic        fp_state_touch,
  output logic [2:0]       fp_round_mode,
  // Hardware loop unit state.
  input  wire logic [31:0] loop0_begin,
  input  wire logic [31:0] loop0_finish,
  input  wire logic [31:0] loop0_count,
  input  wire logic [31:0] loop1_begin,
  input  wire logic [31:0] loop1_finish,
  input  wire logic [31:0] loop1_count,
  // Trap and return events.
  input  wire logic        trap_take,
  input  wire logic        trap_is_irq,
  input  wire logic [4:0]  trap_cause,
  input  wire logic [31:0] trap_pc,
  input  wire logic        trap_return,
  // Fetch redirect and interrupt gating.
  output logic             redirect_valid,
  output logic [31:0]      redirect_pc,
  output logic             global_irq_enable,
  output logic [31:0]      irq_line_enable
);

  // Feature presence derived from configuration.
  localparam bit FP_REGS_PRESENT = float_unit_present && !float_in_int_regs;

  // Stored state.
  logic [4:0]  exc_flags_reg;
  logic [4:0]  exc_flags_next;
  logic [2:0]  round_mode_reg;
  logic [2:0]  round_mode_next;
  logic [1:0]  fp_state_reg;
  logic [1:0]  fp_state_next;
  logic [1:0]  prev_priv_reg;
  logic        prev_irq_en_reg;
  logic        global_irq_en_reg;
  logic [31:0] irq_mask_reg;
  logic [31:8] tvec_base_reg;
  logic        tvec_mode_reg;
  logic [31:0] scratch_reg;
  logic [31:1] return_pc_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic        illegal_reg;
  logic        redirect_valid_reg;
  logic [31:0] redirect_pc_reg;

  // Decode and computed values.
  logic        fp_ok;
  logic        loop_ok;
  logic        hit;
  logic        do_write;
  logic [31:0] cur_val;
  logic [31:0] wval;
  logic [31:0] state_word;
  logic [1:0]  prev_priv_view;
  logic [31:0] tvec_word;
  logic        wr_flags;
  logic        wr_round;
  logic        wr_ctrl;
  logic        wr_state;
  logic        wr_irq_mask;
  logic        wr_tvec;
  logic        wr_scratch;

  // Loop unit values gathered per loop, and their read views.
  logic [31:0] loop_begin_raw   [2];
  logic [31:0] loop_finish_raw  [2];
  logic [31:0] loop_count_raw   [2];
  logic [31:0] loop_begin_view  [2];
  logic [31:0] loop_finish_view [2];
  logic [31:0] loop_count_view  [2];

  assign fp_ok   = float_unit_present;
  assign loop_ok = custom_extension_enable;

  // Both hardware loops enter through the same per-loop view below.
  assign loop_begin_raw[0]  = loop0_begin;
  assign loop_begin_raw[1]  = loop1_begin;
  assign loop_finish_raw[0] = loop0_finish;
  assign loop_finish_raw[1] = loop1_finish;
  assign loop_count_raw[0]  = loop0_count;
  assign loop_count_raw[1]  = loop1_count;

  // Address bits 1:0 are forced to zero here, so a misaligned value from the
  // loop unit can never leak into a read; the count passes through whole.
  for (genvar g = 0; g < 2; g++) begin : g_loop_view
    assign loop_begin_view[g]  = {loop_begin_raw[g][31:2], 2'h0};
    assign loop_finish_view[g] = {loop_finish_raw[g][31:2], 2'h0};
    assign loop_count_view[g]  = loop_count_raw[g];
  end

  // Previous privilege stays at machine level unless user mode exists.
  assign prev_priv_view = user_mode_enable ? prev_priv_reg : CFLM_PRIV_MACHINE;

  // Machine state word assembled from its fields; gaps read zero.
  always_comb begin
    state_word = CFLM_WORD_RESET;
    state_word[CFLM_POS_DIRTY_SUMMARY] = FP_REGS_PRESENT
                                         && (fp_state_reg == CFLM_FP_STATE_DIRTY);
    state_word[CFLM_POS_FP_STATE +: 2] = fp_state_reg;
    state_word[CFLM_POS_PREV_PRIV +: 2] = prev_priv_view;
    state_word[CFLM_POS_PREV_IRQ_EN] = prev_irq_en_reg;
    state_word[CFLM_POS_GLOBAL_IRQ_EN] = global_irq_en_reg;
  end

  // Vector word: low base bits and mode bit 1 always read zero.
  assign tvec_word = {tvec_base_reg, CFLM_TVEC_LOW_ZERO, 1'b0, tvec_mode_reg};

  // Read multiplexer; an absent register counts as unmapped.
  always_comb begin
    cur_val = CFLM_WORD_RESET;
    hit     = 1'b1;
    unique case (csr_addr)
      CFLM_ADDR_FP_EXC_FLAGS: begin
        cur_val = {27'h0, exc_flags_reg};
        hit     = fp_ok;
      end
      CFLM_ADDR_FP_ROUND: begin
        cur_val = {29'h0, round_mode_reg};
        hit     = fp_ok;
      end
      CFLM_ADDR_FP_CTRL_STAT: begin
        cur_val = {24'h0, round_mode_reg, exc_flags_reg};
        hit     = fp_ok;
      end
      CFLM_ADDR_STATE_WORD:  cur_val = state_word;
      CFLM_ADDR_IRQ_ENABLE:  cur_val = irq_mask_reg & CFLM_IRQ_ENABLE_WMASK;
      CFLM_ADDR_TRAP_VECTOR: cur_val = tvec_word;
      CFLM_ADDR_SCRATCHPAD:  cur_val = scratch_reg;
      CFLM_ADDR_LOOP0_BEGIN: begin
        cur_val = loop_begin_view[0];
        hit     = loop_ok;
      end
      CFLM_ADDR_LOOP0_FINISH: begin
        cur_val = loop_finish_view[0];
        hit     = loop_ok;
      end
      CFLM_ADDR_LOOP0_ITER: begin
        cur_val = loop_count_view[0];
        hit     = loop_ok;
      end
      CFLM_ADDR_LOOP1_BEGIN: begin
        cur_val = loop_begin_view[1];
        hit     = loop_ok;
      end
      CFLM_ADDR_LOOP1_FINISH: begin
        cur_val = loop_finish_view[1];
        hit     = loop_ok;
      end
      CFLM_ADDR_LOOP1_ITER: begin
        cur_val = loop_count_view[1];
        hit     = loop_ok;
      end
      default: hit = 1'b0;
    endcase
  end

  // New value of the addressed register for write, set and clear.
  always_comb begin
    wval = cur_val;
    unique case (csr_op)
      CFLM_OP_READ:  wval = cur_val;
      CFLM_OP_WRITE: wval = csr_wdata;
      CFLM_OP_SET:   wval = cur_val | csr_wdata;
      CFLM_OP_CLEAR: wval = cur_val & ~csr_wdata;
    endcase
  end

  // Only mapped writable registers take a write; loop registers never do.
  assign do_write    = csr_req && hit && (csr_op != CFLM_OP_READ);
  assign wr_flags    = do_write && (csr_addr == CFLM_ADDR_FP_EXC_FLAGS);
  assign wr_round    = do_write && (csr_addr == CFLM_ADDR_FP_ROUND);
  assign wr_ctrl     = do_write && (csr_addr == CFLM_ADDR_FP_CTRL_STAT);
  assign wr_state    = do_write && (csr_addr == CFLM_ADDR_STATE_WORD);
  assign wr_irq_mask = do_write && (csr_addr == CFLM_ADDR_IRQ_ENABLE);
  assign wr_tvec     = do_write && (csr_addr == CFLM_ADDR_TRAP_VECTOR);
  assign wr_scratch  = do_write && (csr_addr == CFLM_ADDR_SCRATCHPAD);

  // Flags: a raise from the unit in the same cycle as a clear still lands.
  always_comb begin
    exc_flags_next = exc_flags_reg;
    if (wr_flags || wr_ctrl) begin
      exc_flags_next = wval[4:0];
    end
    exc_flags_next = exc_flags_next | fp_flags_raise;
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !float_unit_present) begin
      exc_flags_reg <= CFLM_FLAGS_RESET;
    end else begin
      exc_flags_reg <= exc_flags_next;
    end
  end

  // Rounding mode keeps any code written, including the invalid ones.
  // Software reads back what it wrote; the arithmetic unit must refuse the bad codes.
  always_comb begin
    round_mode_next = round_mode_reg;
    if (wr_round) begin
      round_mode_next = wval[2:0];
    end else if (wr_ctrl) begin
      round_mode_next = wval[7:5];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !float_unit_present) begin
      round_mode_reg <= CFLM_ROUND_RESET;
    end else begin
      round_mode_reg <= round_mode_next;
    end
  end

  // Float state: any change of float state by the unit or by software marks it dirty.
  // The dirty mark stays until software writes the field again.
  always_comb begin
    fp_state_next = fp_state_reg;
    if (wr_state) begin
      fp_state_next = wval[CFLM_POS_FP_STATE +: 2];
    end
    if (fp_state_touch || wr_flags || wr_round || wr_ctrl || (|fp_flags_raise)) begin
      fp_state_next = CFLM_FP_STATE_DIRTY;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !FP_REGS_PRESENT) begin
      fp_state_reg <= CFLM_FP_STATE_OFF;
    end else begin
      fp_state_reg <= fp_state_next;
    end
  end

  // Previous privilege storage, only meaningful when user mode exists.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_priv_reg <= CFLM_PRIV_MACHINE;
    end else if (wr_state && user_mode_enable) begin
      prev_priv_reg <= wval[CFLM_POS_PREV_PRIV +: 2];
    end
  end

  // Interrupt enables: a trap or return wins over a CSR write in the same cycle,
  // since the instruction that wrote is the one being squashed or retired.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_irq_en_reg   <= 1'b0;
      global_irq_en_reg <= 1'b0;
    end else if (trap_take) begin
      prev_irq_en_reg   <= global_irq_en_reg;
      global_irq_en_reg <= 1'b0;
    end else if (trap_return) begin
      global_irq_en_reg <= prev_irq_en_reg;
      prev_irq_en_reg   <= 1'b1;
    end else if (wr_state) begin
      prev_irq_en_reg   <= wval[CFLM_POS_PREV_IRQ_EN];
      global_irq_en_reg <= wval[CFLM_POS_GLOBAL_IRQ_EN];
    end
  end

  // Interrupt enable mask; unwritable bits are forced to zero.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_mask_reg <= CFLM_WORD_RESET;
    end else if (wr_irq_mask) begin
      irq_mask_reg <= wval & CFLM_IRQ_ENABLE_WMASK;
    end
  end

  // Trap vector; reset takes the boot base and starts in vectored mode.
  // The boot base is sampled for as long as reset is held, so it must be stable then.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tvec_base_reg <= boot_vector_addr[31:8];
      tvec_mode_reg <= CFLM_TVEC_MODE_RESET[0];
    end else if (wr_tvec) begin
      tvec_base_reg <= wval[31:8];
      tvec_mode_reg <= wval[0];
    end
  end

  // Scratch storage with no side effect.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scratch_reg <= CFLM_WORD_RESET;
    end else if (wr_scratch) begin
      scratch_reg <= wval;
    end
  end

  // Return address captured on every trap; bit 0 is never stored.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      return_pc_reg <= CFLM_WORD_RESET[31:1];
    end else if (trap_take) begin
      return_pc_reg <= trap_pc[31:1];
    end
  end

  // Answer one cycle after the request, with the value before any write.
  // Registering the answer costs a cycle but keeps the read path off the pipeline's timing.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_reg  <= 1'b0;
      rdata_reg   <= CFLM_WORD_RESET;
      illegal_reg <= 1'b0;
    end else begin
      rvalid_reg  <= csr_req;
      rdata_reg   <= (csr_req && hit) ? cur_val : CFLM_WORD_RESET;
      illegal_reg <= csr_req && !hit;
    end
  end

  // Fetch redirect; a trap takes priority over a return in the same cycle.
  // Vectored dispatch applies to interrupts only, exceptions use the base.
  // Bit 0 of the saved return address is dropped, so a return lands on an even address.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      redirect_valid_reg <= 1'b0;
      redirect_pc_reg    <= CFLM_WORD_RESET;
    end else begin
      redirect_valid_reg <= trap_take || trap_return;
      if (trap_take) begin
        if (tvec_mode_reg && trap_is_irq) begin
          redirect_pc_reg <= {tvec_base_reg, 1'b0, trap_cause, 2'h0};
        end else begin
          redirect_pc_reg <= {tvec_base_reg, 8'h00};
        end
      end else if (trap_return) begin
        redirect_pc_reg <= {return_pc_reg, 1'b0};
      end
    end
  end

  // Outputs.
  assign csr_rvalid        = rvalid_reg;
  assign csr_rdata         = rdata_reg;
  assign csr_illegal       = illegal_reg;
  assign fp_round_mode     = round_mode_reg;
  assign redirect_valid    = redirect_valid_reg;
  assign redirect_pc       = redirect_pc_reg;
  assign global_irq_enable = global_irq_en_reg;
  assign irq_line_enable   = irq_mask_reg;

endmodule

// ==== cflm_csr_chk.sv ====
// Port-level timing checks for the CSR bank.
`timescale 1ns/1ps
module cflm_csr_chk
  import cflm_csr_pkg::*;
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst_n,
  // CSR port.
  input wire logic        csr_req,
  input wire cflm_op_t    csr_op,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  input wire logic        csr_rvalid,
  input wire logic [31:0] csr_rdata,
  input wire logic        csr_illegal,
  input wire logic [2:0]  fp_round_mode,
  // Trap port.
  input wire logic        trap_take,
  input wire logic        trap_return,
  input wire logic        redirect_valid,
  input wire logic        global_irq_enable,
  input wire logic [31:0] irq_line_enable
);
  logic [31:0] wdata_reg;

  // Every check runs on the core clock and rests while reset is low.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Operand of the previous cycle, compared with the rounding output.
  always_ff @(posedge clk) begin
    wdata_reg <= csr_wdata;
  end

  sequence s_trap_gie;
    trap_take && !trap_return && global_irq_enable ##1 !trap_take;
  endsequence
  sequence s_mret;
    trap_return && !trap_take;
  endsequence

  a_answer_one_cycle: assert property (csr_req |=> csr_rvalid)
    else $error("csr answer missing");
  a_idle_data_zero: assert property (!csr_req |=> !csr_rvalid && csr_rdata == 32'h0)
    else $error("csr answer without request");
  a_illegal_no_data: assert property (csr_illegal |-> csr_rvalid && csr_rdata == 32'h0)
    else $error("illegal answer carries data");
  a_round_direct: assert property (csr_req && csr_op == CFLM_OP_WRITE &&
    csr_addr == CFLM_ADDR_FP_ROUND |=> fp_round_mode == wdata_reg[2:0])
    else $error("rounding write lost");
  a_round_combined: assert property (csr_req && csr_op == CFLM_OP_WRITE &&
    csr_addr == CFLM_ADDR_FP_CTRL_STAT |=> fp_round_mode == wdata_reg[7:5])
    else $error("combined rounding write lost");
  a_round_held: assert property (!csr_req |=> $stable(fp_round_mode))
    else $error("rounding mode changed alone");
  a_irq_mask_zero: assert property ((irq_line_enable & ~CFLM_IRQ_ENABLE_WMASK) == 32'h0)
    else $error("hardwired enable bit set");
  a_trap_redirect: assert property (trap_take |=> redirect_valid && !global_irq_enable)
    else $error("trap not redirected");
  a_mret_restore: assert property (s_trap_gie ##1 s_mret |=> redirect_valid && global_irq_enable)
    else $error("return did not restore enable");
endmodule

bind cflm_csr_bank cflm_csr_chk u_chk (.clk(clk), .rst_n(rst_n), .csr_req(csr_req),
  .csr_op(csr_op), .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_rvalid(csr_rvalid),
  .csr_rdata(csr_rdata), .csr_illegal(csr_illegal), .fp_round_mode(fp_round_mode),
  .trap_take(trap_take), .trap_return(trap_return), .redirect_valid(redirect_valid),
  .global_irq_enable(global_irq_enable), .irq_line_enable(irq_line_enable));

// ==== cflm_pipe_model.sv ====
// Core-side model: loop unit state and floating-point flag events.
`timescale 1ns/1ps
module cflm_pipe_model #(
  parameter logic [31:0] LOOP_PAT = 32'h1357_9bdf
) (
  // Clock.
  input  wire logic        clk,
  // Bench command and model outputs.
  input  wire logic [4:0]  raise_cmd,
  output logic      [4:0]  fp_flags_raise,
  output logic      [31:0] loop_val [6]
);
  // Loop state follows a fixed pattern; low bits are nonzero in every entry but entry 3, so masking shows.
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      loop_val[k] = LOOP_PAT ^ (32'h1111_1111 * k);
    end
  end

  // A flag raise is launched one edge after the bench asks for it.
  always_ff @(posedge clk) begin
    fp_flags_raise <= raise_cmd;
  end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the CSR bank.
`timescale 1ns/1ps
module testbench
  import cflm_csr_pkg::*;
;
  localparam logic [31:0] BOOT = 32'h1234_56ff;
  localparam logic [31:0] LOOP_PAT = 32'h1357_9bdf;
  localparam logic [31:0] VEC0 = {BOOT[31:8], 8'h01};
  logic clk, rst_n, csr_req, csr_rvalid, csr_illegal, trap_take, trap_is_irq, trap_return;
  logic redirect_valid, global_irq_enable, touch;
  cflm_op_t csr_op;
  logic [11:0] csr_addr;
  logic [31:0] csr_wdata, csr_rdata, trap_pc, redirect_pc, irq_line_enable;
  logic [31:0] lv [6];
  logic [4:0] raise, fp_flags_raise, trap_cause;
  logic [2:0] fp_round_mode;
  int bad_count, tests_run, cyc;

  cflm_csr_bank dut (.clk(clk), .rst_n(rst_n), .boot_vector_addr(BOOT), .csr_req(csr_req),
    .csr_op(csr_op), .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_rvalid(csr_rvalid),
    .csr_rdata(csr_rdata), .csr_illegal(csr_illegal), .fp_flags_raise(fp_flags_raise),
    .fp_state_touch(touch), .fp_round_mode(fp_round_mode), .loop0_begin(lv[0]),
    .loop0_finish(lv[1]), .loop0_count(lv[2]), .loop1_begin(lv[3]), .loop1_finish(lv[4]),
    .loop1_count(lv[5]), .trap_take(trap_take), .trap_is_irq(trap_is_irq),
    .trap_cause(trap_cause), .trap_pc(trap_pc), .trap_return(trap_return),
    .redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
    .global_irq_enable(global_irq_enable), .irq_line_enable(irq_line_enable));
  cflm_pipe_model #(.LOOP_PAT(LOOP_PAT)) u_pipe (.clk(clk), .raise_cmd(raise),
    .fp_flags_raise(fp_flags_raise), .loop_val(lv));

  // Clock and a cycle ceiling that cuts a hang short.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // Request stays high so back-to-back calls never toggle it in one step.
  task automatic csr(input cflm_op_t op, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic il);
    csr_req = 1;
    csr_op = op;
    csr_addr = a;
    csr_wdata = d;
    @(posedge clk);
    #1;
    chk("csr_rvalid", csr_rvalid, 1);
    chk("csr_rdata", csr_rdata, e);
    chk("csr_illegal", csr_illegal, il);
  endtask

  task automatic idle();
    csr_req = 0;
    @(posedge clk);
    #1;
  endtask

  task automatic trap(input logic t, r, q, input logic [4:0] c, input logic [31:0] pc, ep,
                      input logic eg);
    trap_take = t;
    trap_return = r;
    trap_is_irq = q;
    trap_cause = c;
    trap_pc = pc;
    @(posedge clk);
    #1;
    chk("redirect_valid", redirect_valid, 1);
    chk("redirect_pc", redirect_pc, ep);
    chk("global_irq_enable", global_irq_enable, eg);
    trap_take = 0;
    trap_return = 0;
    @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    csr(CFLM_OP_READ, CFLM_ADDR_STATE_WORD, 0, 32'h0000_1800, 0);
    csr(CFLM_OP_READ, CFLM_ADDR_TRAP_VECTOR, 0, VEC0, 0);
    csr(CFLM_OP_READ, CFLM_ADDR_FP_CTRL_STAT, 0, 32'h0, 0);
    csr(CFLM_OP_WRITE, 12'h7a0, 32'h1, 32'h0, 1);
    idle();
  endtask

  task automatic t_fp();
    csr(CFLM_OP_WRITE, CFLM_ADDR_FP_EXC_FLAGS, 32'hffff_ffff, 0, 0);
    csr(CFLM_OP_READ, CFLM_ADDR_FP_EXC_FLAGS, 0, 32'h1f, 0);
    for (int i = 0; i < 8; i++) begin
      csr(CFLM_OP_WRITE, CFLM_ADDR_FP_ROUND, 32'hffff_fff8 | i, (i == 0) ? 0 : i - 1, 0);
    end
    csr(CFLM_OP_WRITE, CFLM_ADDR_FP_CTRL_STAT, 32'hffff_ff45, 32'hff, 0);
    csr(CFLM_OP_READ, CFLM_ADDR_FP_ROUND, 0, 32'h2, 0);
    chk("fp_round_mode", fp_round_mode, 32'h2);
    csr(CFLM_OP_READ, CFLM_ADDR_STATE_WORD, 0, 32'h8000_7800, 0);
    csr(CFLM_OP_WRITE, CFLM_ADDR_STATE_WORD, 32'h2000, 32'h8000_7800, 0);
    csr(CFLM_OP_READ, CFLM_ADDR_STATE_WORD, 0, 32'h0000_3800, 0);
    raise = 5'h02;
    idle();
    raise = 5'h00;
    idle();
    csr(CFLM_OP_READ, CFLM_ADDR_FP_EXC_FLAGS, 0, 32'h07, 0);
    csr(CFLM_OP_READ, CFLM_ADDR_STATE_WORD, 0, 32'h8000_7800, 0);
    csr(CFLM_OP_WRITE, CFLM_ADDR_STATE_WORD, 32'h2000, 32'h8000_7800, 0);
    touch = 1;
    idle();
    touch = 0;
    csr(CFLM_OP_READ, CFLM_ADDR_STATE_WORD, 0, 32'h8000_7800, 0);
    idle();
  endtask

  task automatic t_loop();
    logic [11:0] a;
    logic [31:0] e;
    for (int k = 0; k < 6; k++) begin
      a = 12'hcc0 + 12'((k / 3) * 4 + k % 3);
      e = (LOOP_PAT ^ (32'h1111_1111 * k)) & ((k % 3 == 2) ? 32'hffff_ffff : 32'hffff_fffc);
      csr(CFLM_OP_WRITE, a, 32'h0, e, 0);
      csr(CFLM_OP_READ, a, 0, e, 0);
    end
    idle();
  endtask

  task automatic t_irq_scratch();
    csr(CFLM_OP_WRITE, CFLM_ADDR_IRQ_ENABLE, 32'hffff_ffff, 0, 0);
    csr(CFLM_OP_CLEAR, CFLM_ADDR_IRQ_ENABLE, 32'h0001_0800, 32'hffff_0888, 0);
    csr(CFLM_OP_READ, CFLM_ADDR_IRQ_ENABLE, 0, 32'hfffe_0088, 0);
    chk("irq_line_enable", irq_line_enable, 32'hfffe_0088);
    csr(CFLM_OP_WRITE, CFLM_ADDR_SCRATCHPAD, 32'ha5a5_5a5a, 0, 0);
    csr(CFLM_OP_SET, CFLM_ADDR_SCRATCHPAD, 32'h0f00_0000, 32'ha5a5_5a5a, 0);
    csr(CFLM_OP_CLEAR, CFLM_ADDR_SCRATCHPAD, 32'hffff_0000, 32'hafa5_5a5a, 0);
    csr(CFLM_OP_READ, CFLM_ADDR_SCRATCHPAD, 0, 32'h0000_5a5a, 0);
    idle();
  endtask

  task automatic t_trap();
    csr(CFLM_OP_WRITE, CFLM_ADDR_TRAP_VECTOR, 32'habcd_efff, VEC0, 0);
    csr(CFLM_OP_SET, CFLM_ADDR_STATE_WORD, 32'h8, 32'h8000_7800, 0);
    csr(CFLM_OP_READ, CFLM_ADDR_TRAP_VECTOR, 0, 32'habcd_ef01, 0);
    idle();
    trap(1, 0, 1, 5'd7, 32'h0000_4444, 32'habcd_ef1c, 0);
    trap(0, 1, 0, 5'd0, 32'h0, 32'h0000_4444, 1);
    trap(1, 0, 0, 5'd3, 32'h0000_5550, 32'habcd_ef00, 0);
    csr(CFLM_OP_WRITE, CFLM_ADDR_TRAP_VECTOR, 32'habcd_ef00, 32'habcd_ef01, 0);
    idle();
    trap(1, 0, 1, 5'd7, 32'h0, 32'habcd_ef00, 0);
  endtask

  // Main sequence: all inputs defined at time zero, reset for eight cycles.
  initial begin
    clk = 0;
    rst_n = 0;
    csr_req = 0;
    csr_op = CFLM_OP_READ;
    csr_addr = 0;
    csr_wdata = 0;
    raise = 0;
    touch = 0;
    trap_take = 0;
    trap_return = 0;
    trap_is_irq = 0;
    trap_cause = 0;
    trap_pc = 0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1;
    t_reset();
    t_fp();
    t_loop();
    t_irq_scratch();
    t_trap();
    test_done();
  end
endmodule
